// ### csat_timing_ctrl.sv
// current-sense adc timing control: settling waits and conversion pacing
`timescale 1ns/10ps
// Overview of operation
// - continuous refresh period follows decimation code
// - single conversion time follows decimation code
// - wait cs adc settling before valid results
// - wait afe settling on each active entry
// - intervals stay within 1.5 percent nominal
module csat_timing_ctrl #(
  parameter int AFE_SETTLE_CYC = csat_pkg::AFE_SETTLE_CYC,
  parameter int CONV_CYC_11 = csat_pkg::CONV_CYC_11,
  parameter int REFRESH_CYC_11 = csat_pkg::REFRESH_CYC_11,
  parameter int DATA_W = 24
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic active_mode,
  input wire logic cs_enable,
  input wire logic continuous_mode,
  input wire logic single_start,
  input wire logic [1:0] current_sense_decimation_select,
  input wire logic [DATA_W-1:0] cs_filter_data,
  output logic [DATA_W-1:0] cs_result,
  output logic cs_result_update,
  output logic afe_ready,
  output logic cs_valid,
  output logic single_busy,
  output logic single_done
);
  localparam int CW = csat_pkg::CNT_W + 7;

  csat_pkg::csat_state_t state;
  csat_pkg::csat_state_t next_state;
  logic [CW-1:0] cnt;
  logic [1:0] decim;
  logic active_prev;

  // ----------------------------------------------------------------
  // interval selection
  // ----------------------------------------------------------------
  wire logic [CW-1:0] refresh_len =
    (decim == 2'h3) ? CW'(REFRESH_CYC_11) :
    (decim == 2'h2) ? CW'(csat_pkg::REFRESH_CYC_10) :
    (decim == 2'h1) ? CW'(csat_pkg::REFRESH_CYC_01) :
    CW'(csat_pkg::REFRESH_CYC_00);
  wire logic [CW-1:0] conv_len =
    (decim == 2'h3) ? CW'(CONV_CYC_11) :
    (decim == 2'h2) ? CW'(csat_pkg::CONV_CYC_10) :
    (decim == 2'h1) ? CW'(csat_pkg::CONV_CYC_01) :
    CW'(csat_pkg::CONV_CYC_00);
  wire logic active_entry = active_mode && !active_prev;
  wire logic cnt_last = (cnt == CW'(1));
  wire logic go_run = cs_enable && (continuous_mode || single_start);
  wire logic start_cont = continuous_mode && cs_enable;

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      csat_pkg::CSAT_IDLE: begin
        if (active_entry) next_state = csat_pkg::CSAT_AFE_WAIT;
        else if (active_mode && go_run) next_state = csat_pkg::CSAT_SETTLE;
      end
      csat_pkg::CSAT_AFE_WAIT: begin
        if (cnt_last) next_state = csat_pkg::CSAT_IDLE;
      end
      csat_pkg::CSAT_SETTLE: begin
        if (cnt_last) begin
          next_state = start_cont ? csat_pkg::CSAT_CONT : csat_pkg::CSAT_SINGLE;
        end
      end
      csat_pkg::CSAT_CONT: begin
        if (!start_cont) next_state = csat_pkg::CSAT_IDLE;
      end
      csat_pkg::CSAT_SINGLE: begin
        if (cnt_last) next_state = csat_pkg::CSAT_IDLE;
      end
      default: next_state = csat_pkg::CSAT_IDLE;
    endcase
    if (!active_mode) next_state = csat_pkg::CSAT_IDLE;
  end

  wire logic load_afe = (state == csat_pkg::CSAT_IDLE) && active_entry;
  wire logic load_settle = (state == csat_pkg::CSAT_IDLE) && !active_entry &&
    active_mode && go_run;
  wire logic settle_done = (state == csat_pkg::CSAT_SETTLE) && cnt_last;
  wire logic period_end = (state == csat_pkg::CSAT_CONT) && cnt_last;
  wire logic single_end = (state == csat_pkg::CSAT_SINGLE) && cnt_last;

  // the counter always counts down so every interval is an exact cycle count
  wire logic [CW-1:0] next_cnt =
    load_afe ? CW'(AFE_SETTLE_CYC) :
    load_settle ? CW'(csat_pkg::CS_SETTLE_CYC) :
    (settle_done && start_cont) ? refresh_len :
    settle_done ? conv_len :
    period_end ? refresh_len :
    (cnt != '0) ? cnt - CW'(1) : cnt;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= csat_pkg::CSAT_IDLE;
      cnt <= '0;
      active_prev <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= (next_state == csat_pkg::CSAT_IDLE) ? '0 : next_cnt;
      active_prev <= active_mode;
    end
  end

  // decimation is latched only when idle so a period never changes length midway
  always_ff @(posedge clk_sys) begin
    if (rst) decim <= csat_pkg::DECIM_RESET;
    else if (state == csat_pkg::CSAT_IDLE) decim <= current_sense_decimation_select;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cs_result <= '0;
      cs_result_update <= 1'b0;
      afe_ready <= 1'b0;
      cs_valid <= 1'b0;
      single_busy <= 1'b0;
      single_done <= 1'b0;
    end else begin
      cs_result_update <= period_end || single_end;
      if (period_end || single_end) cs_result <= cs_filter_data;
      afe_ready <= active_mode && (next_state != csat_pkg::CSAT_AFE_WAIT);
      cs_valid <= (next_state == csat_pkg::CSAT_CONT) ||
        (next_state == csat_pkg::CSAT_SINGLE);
      single_busy <= (next_state == csat_pkg::CSAT_SINGLE);
      single_done <= single_end;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  int unsigned upd_gap;
  always_ff @(posedge clk_sys) begin
    if (rst || cs_result_update || state != csat_pkg::CSAT_CONT) upd_gap <= 0;
    else upd_gap <= upd_gap + 1;
  end

  // dwell counter: cycles spent in the present state, restarted at each refresh,
  // so every interval is measured on the clock and not read back from the down-counter
  int unsigned stay_cyc;
  always_ff @(posedge clk_sys) begin
    if (rst || (state != next_state) || period_end) stay_cyc <= 32'h1;
    else stay_cyc <= stay_cyc + 32'h1;
  end

  // tolerance band in thousandths of the nominal period
  wire logic [63:0] stay_milli = 64'(stay_cyc) * 64'h3E8;
  wire logic [63:0] tol_lo = 64'(refresh_len) * (64'h3E8 - 64'(csat_pkg::TOL_PERMILLE));
  wire logic [63:0] tol_hi = 64'(refresh_len) * (64'h3E8 + 64'(csat_pkg::TOL_PERMILLE));

  a_refresh_period: assert property (@(posedge clk_sys) disable iff (rst)
    upd_gap <= int'(refresh_len))
    else $error("refresh period exceeded");
  a_period_update: assert property (@(posedge clk_sys) disable iff (rst)
    period_end |=> cs_result_update && cs_result == $past(cs_filter_data))
    else $error("result not updated at period end");
  a_settle_first: assert property (@(posedge clk_sys) disable iff (rst)
    load_settle |=> !cs_valid [*8])
    else $error("valid before settling");
  a_afe_wait: assert property (@(posedge clk_sys) disable iff (rst)
    (load_afe && active_mode) |=> !afe_ready)
    else $error("afe ready during settling");
  a_single_len: assert property (@(posedge clk_sys) disable iff (rst)
    single_end |=> single_done ##1 !single_done)
    else $error("single done not a pulse");
  a_interval_tol: assert property (@(posedge clk_sys) disable iff (rst)
    period_end |-> (stay_milli >= tol_lo) && (stay_milli <= tol_hi))
    else $error("interval outside tolerance band");
  a_cont_exact: assert property (@(posedge clk_sys) disable iff (rst)
    period_end |-> stay_cyc == 32'(refresh_len))
    else $error("refresh period length wrong");
  a_afe_len: assert property (@(posedge clk_sys) disable iff (rst)
    (state == csat_pkg::CSAT_AFE_WAIT && cnt_last) |-> stay_cyc == AFE_SETTLE_CYC)
    else $error("afe settling length wrong");
  a_entry_afe: assert property (@(posedge clk_sys) disable iff (rst)
    load_afe |=> state == csat_pkg::CSAT_AFE_WAIT)
    else $error("active entry did not start afe wait");
  a_afe_inactive: assert property (@(posedge clk_sys) disable iff (rst)
    afe_ready |-> $past(active_mode))
    else $error("afe ready outside active mode");
  a_settle_len: assert property (@(posedge clk_sys) disable iff (rst)
    settle_done |-> stay_cyc == csat_pkg::CS_SETTLE_CYC)
    else $error("cs settling length wrong");
  a_valid_idle: assert property (@(posedge clk_sys) disable iff (rst)
    (state == csat_pkg::CSAT_IDLE) |-> !cs_valid)
    else $error("valid while idle");
  a_single_conv: assert property (@(posedge clk_sys) disable iff (rst)
    single_end |-> stay_cyc == 32'(conv_len))
    else $error("single conversion length wrong");
  a_decim_hold: assert property (@(posedge clk_sys) disable iff (rst)
    ($past(state) != csat_pkg::CSAT_IDLE) |-> $stable(decim))
    else $error("decimation changed while running");
  a_update_pulse: assert property (@(posedge clk_sys) disable iff (rst)
    cs_result_update |=> !cs_result_update)
    else $error("result update longer than one cycle");
  a_valid_active: assert property (@(posedge clk_sys) disable iff (rst)
    cs_valid |-> $past(active_mode))
    else $error("valid outside active mode");
  a_single_busy: assert property (@(posedge clk_sys) disable iff (rst)
    single_done |-> $past(single_busy))
    else $error("done without busy");

  c_cont_update: cover property (@(posedge clk_sys) cs_result_update && continuous_mode);
  c_single: cover property (@(posedge clk_sys) single_done);
  c_afe: cover property (@(posedge clk_sys) load_afe);
  c_settle: cover property (@(posedge clk_sys) settle_done);
  // leaving continuous mode mid-period must return cleanly to idle
  c_cont_leave: cover property (@(posedge clk_sys) state == csat_pkg::CSAT_CONT && !start_cont);
endmodule : csat_timing_ctrl

// ### csat_pkg.sv
// package: constants for the current-sense adc timing control
package csat_pkg;
  // ----------------------------------------------------------------
  // clock
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  // ----------------------------------------------------------------
  // refresh periods in ns per decimation code
  // ----------------------------------------------------------------
  localparam int REFRESH_NS_11 = 4096000;
  localparam int REFRESH_NS_10 = 1024000;
  localparam int REFRESH_NS_01 = 512000;
  localparam int REFRESH_NS_00 = 256000;
  localparam int REFRESH_CYC_11 = REFRESH_NS_11 * CLK_MHZ / 1000;
  localparam int REFRESH_CYC_10 = REFRESH_NS_10 * CLK_MHZ / 1000;
  localparam int REFRESH_CYC_01 = REFRESH_NS_01 * CLK_MHZ / 1000;
  localparam int REFRESH_CYC_00 = REFRESH_NS_00 * CLK_MHZ / 1000;
  // ----------------------------------------------------------------
  // single conversion times in ns per decimation code
  // ----------------------------------------------------------------
  localparam int CONV_NS_11 = 12350000;
  localparam int CONV_NS_10 = 3134000;
  localparam int CONV_NS_01 = 1598000;
  localparam int CONV_NS_00 = 830000;
  localparam int CONV_CYC_11 = CONV_NS_11 / 1000 * CLK_MHZ;
  localparam int CONV_CYC_10 = CONV_NS_10 / 1000 * CLK_MHZ;
  localparam int CONV_CYC_01 = CONV_NS_01 / 1000 * CLK_MHZ;
  localparam int CONV_CYC_00 = CONV_NS_00 / 1000 * CLK_MHZ;
  // ----------------------------------------------------------------
  // settling times
  // ----------------------------------------------------------------
  localparam int CS_SETTLE_US = 62;
  localparam int CS_SETTLE_CYC = CS_SETTLE_US * CLK_MHZ;
  localparam int AFE_SETTLE_MS = 4;
  localparam int AFE_SETTLE_CYC = AFE_SETTLE_MS * 1000 * CLK_MHZ;
  // tolerance in tenths of a percent
  localparam int TOL_PERMILLE = 15;
  localparam int CNT_W = 24;
  localparam logic [1:0] DECIM_RESET = 2'h0;
  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CSAT_IDLE = 3'b000,
    CSAT_AFE_WAIT = 3'b001,
    CSAT_SETTLE = 3'b010,
    CSAT_CONT = 3'b011,
    CSAT_SINGLE = 3'b100
  } csat_state_t;
endpackage : csat_pkg

// ### csat_cs_source.sv
// shunt current-sense source: filtered adc data that steps every eight clocks
`timescale 1ns/10ps
module csat_cs_source (
  input wire logic clk_sys,
  input wire logic rst,
  output logic [23:0] cs_filter_data
);
  logic [2:0] tick;
  // slow steps keep the sample moment readable without hiding a stale result
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tick <= 3'h0;
      cs_filter_data <= 24'h000000;
    end else begin
      tick <= tick + 3'h1;
      if (tick == 3'h7) begin
        cs_filter_data <= cs_filter_data + 24'h010101;
      end
    end
  end
endmodule : csat_cs_source

// ### csat_timing_ctrl_bench.sv
// self-checking bench for the current-sense adc timing control
`timescale 1ns/10ps
module csat_timing_ctrl_bench;
  logic clk_sys, rst, active_mode, cs_enable, continuous_mode, single_start;
  logic [1:0] dsel;
  logic [23:0] src_data, prev_data, cs_result;
  logic cs_result_update, afe_ready, cs_valid, single_busy, single_done;
  int err_count = 0;
  int cmp_count = 0;
  csat_cs_source src (.clk_sys(clk_sys), .rst(rst), .cs_filter_data(src_data));
  csat_timing_ctrl #(.AFE_SETTLE_CYC(20), .CONV_CYC_11(50), .REFRESH_CYC_11(40)) DUT (
    .clk_sys(clk_sys), .rst(rst), .active_mode(active_mode), .cs_enable(cs_enable),
    .continuous_mode(continuous_mode), .single_start(single_start),
    .current_sense_decimation_select(dsel), .cs_filter_data(src_data),
    .cs_result(cs_result), .cs_result_update(cs_result_update), .afe_ready(afe_ready),
    .cs_valid(cs_valid), .single_busy(single_busy), .single_done(single_done));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  always @(posedge clk_sys) prev_data <= src_data;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %0d seen %0d", what, exp, seen);
    end
  endtask : check
  // tolerance band plus one cycle for the registered output
  function automatic logic [31:0] near(input int n, input int exp);
    return ((n - exp) * 1000 <= exp * 15 + 1000 && (exp - n) * 1000 <= exp * 15) ? 1 : 0;
  endfunction : near
  function automatic logic pick(input int s);
    case (s)
      0: return afe_ready;
      1: return cs_valid;
      2: return cs_result_update;
      default: return single_done;
    endcase
  endfunction : pick
  task automatic cycles_to(input int s, output int n);
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (pick(s) !== 1'b1 && n < 500000);
  endtask : cycles_to
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_enter;
    int n;
    @(negedge clk_sys);
    {active_mode, cs_enable, continuous_mode, single_start} = 4'h0;
    repeat (3) @(negedge clk_sys);
    check("afe_ready_off", afe_ready, 0);
    active_mode = 1'b1;
    cycles_to(0, n);
    check("afe_settle", near(n, 20), 1);
    $display("test entry settle done");
  endtask : t_enter
  task automatic t_cont(input logic [1:0] code, input int period);
    int n;
    t_enter();
    dsel = code;
    {cs_enable, continuous_mode} = 2'h3;
    cycles_to(1, n);
    check("cs_settle", near(n, 6200), 1);
    cycles_to(2, n);
    check("refresh_first", n, period);
    cycles_to(2, n);
    check("refresh_gap", n, period);
    check("cs_result", cs_result, prev_data);
    @(negedge clk_sys);
    check("update_pulse", cs_result_update, 0);
    $display("test continuous code %0d done", code);
  endtask : t_cont
  task automatic t_single(input logic [1:0] code, input int conv);
    int n;
    t_enter();
    dsel = code;
    {cs_enable, single_start} = 2'h3;
    cycles_to(1, n);
    single_start = 1'b0;
    check("single_settle", near(n, 6200), 1);
    check("single_busy", single_busy, 1);
    cycles_to(3, n);
    check("conv_time", n, conv);
    check("single_update", cs_result_update, 1);
    check("single_result", cs_result, prev_data);
    @(negedge clk_sys);
    check("valid_after", cs_valid, 0);
    $display("test single code %0d done", code);
  endtask : t_single
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  // ----------------------------------------------------------------
  // clock, reset, sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    {rst, active_mode, cs_enable, continuous_mode, single_start} = 5'h10;
    dsel = 2'h0;
    repeat (6) @(negedge clk_sys);
    rst = 1'b0;
    t_cont(2'h3, 40);
    t_cont(2'h0, 25600);
    t_single(2'h3, 50);
    print_verdict();
  end
  initial begin
    repeat (90000) @(posedge clk_sys);
    err_count++;
    print_verdict();
  end
endmodule : csat_timing_ctrl_bench
